// [logic/pmc_pkg.sv]
// Purpose: constants and types for the peripheral macro control register bank
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: register values are 8 bits wide and sit in the low byte of the word
// Notes on behaviour
// RULE1: External clock select bit 4 feeds oscillator from main supply, feedback resistor off.
// RULE2: Writes to oscillator register bits 2, 3 and 7 are ignored.
// RULE3: Software writes zero to oscillator register bits 0, 1, 5 and 6.
// RULE4: Oscillator register reads zero in bits 0,1,5,6 and one in 2,3,7.
// RULE5: Any reset loads the oscillator register with 8ch.
// RULE6: Macro control register is eight bits, read/write, reset to 00h.
// RULE7: Bits 7:6 pick PLL multiplier x2, x4, x3; value 11 is forbidden.
// RULE8: Bit 5 sets serial clock pin direction, 1 is output.
// RULE9: Bit 4 sets serial clock polarity, 1 is inverted.
// RULE10: Bit 3 picks read strobe style, 0 for 80-style, 1 for 68-style.
// RULE11: Media block clock runs while bit 2 is 0, stops when 1.
// RULE12: USB DMA clock runs while bit 1 is 0, stops when 1.
// RULE13: USB macro held in reset while bit 0 is 0.
// RULE14: Macro control reads back last written value without side effects.
package pmc_pkg;
   localparam logic [11:0] PMC_OSC_OFFSET = 12'h000;
   localparam logic [11:0] PMC_MACRO_OFFSET = 12'h004;
   localparam logic [7:0] PMC_OSC_RESET = 8'h8c;
   localparam logic [7:0] PMC_MACRO_RESET = 8'h00;
   localparam logic [7:0] PMC_OSC_ONES = 8'h8c;
   localparam logic [7:0] PMC_OSC_WMASK = 8'h10;
   localparam int PMC_EXT_CLK_BIT = 4;

   // PLL multiplier selection as coded in bits 7:6
   typedef enum logic [1:0] {
      PMC_PLL_X2 = 2'b00,
      PMC_PLL_X4 = 2'b01,
      PMC_PLL_X3 = 2'b10,
      PMC_PLL_BAD = 2'b11
   } pmc_pll_t;

   // Layout of the macro control register
   typedef struct packed {
      pmc_pll_t pllMultSel;
      logic serialClockDirection;
      logic serialClockPolarity;
      logic strobeStyleSelect;
      logic mediaClockGate;
      logic usbDmaClockGate;
      logic usbMacroResetRelease;
   } pmc_macro_t;

   // Controls handed to the oscillator and macros
   typedef struct packed {
      logic oscFromMainSupply;
      logic oscFeedbackOff;
      pmc_pll_t pllMultSel;
      logic pllSelectBad;
      logic serialClockOutEn;
      logic serialClockInvert;
      logic strobeStyle68;
      logic mediaClockEn;
      logic usbDmaClockEn;
      logic usbMacroReset;
   } pmc_ctrl_t;
endpackage

// [logic/pmc_apb_slave.sv]
// Purpose: APB slave front end with single-wait access and byte lane handling
// Assumes: same clock as the register bank
// Notes: answers every transfer in its second access cycle
`timescale 1ns/1ps
module pmc_apb_slave (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [3:0] pstrb,
   output logic pready,
   // Register side
   output logic wrOsc,
   output logic wrMacro,
   output logic rdHit,
   output logic [1:0] rdSel
);
   import pmc_pkg::*;
   logic ready_q;
   logic ready_d;
   logic decOsc;
   logic decMacro;
   logic commit;

   // One wait state keeps read data settled from a register
   always_comb begin
      ready_d = psel & penable & ~ready_q;
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= ready_d;
      end
   end

   assign pready = ready_q;
   assign decOsc = (paddr == PMC_OSC_OFFSET);
   assign decMacro = (paddr == PMC_MACRO_OFFSET);
   assign commit = psel & penable & ready_q;
   // Only the low byte lane holds data, so it gates the write
   assign wrOsc = commit & pwrite & pstrb[0] & decOsc;
   assign wrMacro = commit & pwrite & pstrb[0] & decMacro;
   assign rdHit = psel & penable & ~pwrite & ~ready_q;
   assign rdSel = {decMacro, decOsc};
endmodule

// [logic/pmc_regs.sv]
// Purpose: oscillator input control and internal macro control registers
// Assumes: APB master keeps request stable until pready
// Notes: outputs are registered except pslverr, tied low; unmapped addresses read zero, no error
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
module pmc_regs (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // APB slave port
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Controls to oscillator and macros
   output pmc_pkg::pmc_ctrl_t ctrl
);
   import pmc_pkg::*;
   logic [7:0] osc_q;
   logic [7:0] osc_d;
   pmc_macro_t macro_q;
   pmc_macro_t macro_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   pmc_ctrl_t ctrl_q;
   pmc_ctrl_t ctrl_d;
   logic wrOsc;
   logic wrMacro;
   logic rdHit;
   logic [1:0] rdSel;
   logic [7:0] oscView;

   // Bus front end
   pmc_apb_slave u_slave (
      .clk(clk),
      .sys_rst(sys_rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pstrb(pstrb),
      .pready(pready),
      .wrOsc(wrOsc),
      .wrMacro(wrMacro),
      .rdHit(rdHit),
      .rdSel(rdSel)
   );

   // Only bit 4 stores; fixed bits never take write data
   always_comb begin
      osc_d = osc_q;
      if (wrOsc) begin
         osc_d = (pwdata[7:0] & PMC_OSC_WMASK) | PMC_OSC_ONES; // RULE2
      end
   end

   // Full eight-bit store, reads have no effect on it
   always_comb begin
      macro_d = macro_q;
      if (wrMacro) begin
         macro_d = pmc_macro_t'(pwdata[7:0]); // RULE6 RULE14
      end
   end

   // Read view forces the fixed bits whatever is stored
   assign oscView = (osc_q & PMC_OSC_WMASK) | PMC_OSC_ONES; // RULE4

   // Read data captured in the wait cycle, presented with pready
   always_comb begin
      rdata_d = rdata_q;
      if (rdHit) begin
         case (rdSel)
            2'b01: rdata_d = {24'h000000, oscView};
            2'b10: rdata_d = {24'h000000, macro_q}; // RULE14
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   // Decode of stored fields into macro controls
   always_comb begin
      ctrl_d.oscFromMainSupply = osc_q[PMC_EXT_CLK_BIT]; // RULE1
      ctrl_d.oscFeedbackOff = osc_q[PMC_EXT_CLK_BIT]; // RULE1
      ctrl_d.pllMultSel = macro_q.pllMultSel; // RULE7
      // Forbidden code is flagged, not corrected; the PLL sees it as written
      ctrl_d.pllSelectBad = (macro_q.pllMultSel == PMC_PLL_BAD); // RULE7
      ctrl_d.serialClockOutEn = macro_q.serialClockDirection; // RULE8
      ctrl_d.serialClockInvert = macro_q.serialClockPolarity; // RULE9
      ctrl_d.strobeStyle68 = macro_q.strobeStyleSelect; // RULE10
      ctrl_d.mediaClockEn = ~macro_q.mediaClockGate; // RULE11
      ctrl_d.usbDmaClockEn = ~macro_q.usbDmaClockGate; // RULE12
      ctrl_d.usbMacroReset = ~macro_q.usbMacroResetRelease; // RULE13
   end

   // State registers; sys_rst stands for every chip reset source
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         osc_q <= PMC_OSC_RESET; // RULE5
         macro_q <= pmc_macro_t'(PMC_MACRO_RESET); // RULE6
         rdata_q <= 32'h00000000;
         ctrl_q <= '0;
         ctrl_q.usbMacroReset <= 1'b1; // RULE13
         ctrl_q.mediaClockEn <= 1'b1;
         ctrl_q.usbDmaClockEn <= 1'b1;
      end else begin
         osc_q <= osc_d;
         macro_q <= macro_d;
         rdata_q <= rdata_d;
         ctrl_q <= ctrl_d;
      end
   end

   assign prdata = rdata_q;
   assign ctrl = ctrl_q;
   assign pslverr = 1'b0;
endmodule

// [verification/pmc_regs_asserts.sv]
// Purpose: port-level checks on the register bank controls
// Assumes: ctrl follows a committed write by two edges
// Notes: checks only writes with the low byte lane enabled
`timescale 1ns/1ps
module pmc_regs_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   // Controls
   input wire pmc_pkg::pmc_ctrl_t ctrl
);
   import pmc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Committed writes; a new one cannot commit within the next two cycles
   wire cmt = psel && penable && pready && pwrite && pstrb[0];
   wire wm = cmt && paddr == PMC_MACRO_OFFSET;
   wire wo = cmt && paddr == PMC_OSC_OFFSET;
   property p_pll; wm |-> ##2 ctrl.pllMultSel == $past(pwdata[7:6], 2); endproperty
   a_pll: assert property (p_pll) else $error("pll select wrong");
   property p_dir; wm |-> ##2 ctrl.serialClockOutEn == $past(pwdata[5], 2); endproperty
   a_dir: assert property (p_dir) else $error("direction wrong");
   property p_pol; wm |-> ##2 ctrl.serialClockInvert == $past(pwdata[4], 2); endproperty
   a_pol: assert property (p_pol) else $error("polarity wrong");
   property p_stb; wm |-> ##2 ctrl.strobeStyle68 == $past(pwdata[3], 2); endproperty
   a_stb: assert property (p_stb) else $error("strobe style wrong");
   property p_med; wm && pwdata[2] |-> ##2 !ctrl.mediaClockEn [*2]; endproperty
   a_med: assert property (p_med) else $error("media clock not stopped");
   property p_dma; wm |-> ##2 ctrl.usbDmaClockEn != $past(pwdata[1], 2); endproperty
   a_dma: assert property (p_dma) else $error("dma clock wrong");
   property p_usb; wm && !pwdata[0] |-> ##2 ctrl.usbMacroReset [*2]; endproperty
   a_usb: assert property (p_usb) else $error("usb macro not in reset");
   property p_osc; wo |-> ##2 ctrl.oscFeedbackOff == $past(pwdata[4], 2); endproperty
   a_osc: assert property (p_osc) else $error("external clock select wrong");
endmodule

// [verification/pmc_macro_model.sv]
// Purpose: far-side macros seen as gated clock activity counters
// Assumes: a stopped clock leaves its counter frozen
// Notes: dma side is cleared while the usb macro is held in reset
`timescale 1ns/1ps
module pmc_macro_model (
   // Clock and controls
   input wire logic clk,
   input wire logic sys_rst,
   input wire pmc_pkg::pmc_ctrl_t ctrl,
   // Activity seen by the macros
   output logic [7:0] mediaTicks,
   output logic [7:0] dmaTicks
);
   import pmc_pkg::*;
   // Ticks stand for gated clock edges
   always_ff @(posedge clk) begin
      if (sys_rst) mediaTicks <= 8'h00;
      else if (ctrl.mediaClockEn) mediaTicks <= mediaTicks + 8'h01;
      if (sys_rst || ctrl.usbMacroReset) dmaTicks <= 8'h00;
      else if (ctrl.usbDmaClockEn) dmaTicks <= dmaTicks + 8'h01;
   end
endmodule

// [verification/test_pmc_regs.sv]
// Purpose: APB-driven checks of the register bank
// Assumes: one wait state, answer awaited on pready
// Notes: ctrl slice compares rely on the package field order
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin failures++; \
   $display("wrong value at %0t: got %h", $time, a); end end
module test_pmc_regs;
   import pmc_pkg::*;
   logic clk = '0, sys_rst = '1, psel = '0, penable = '0, pwrite = '0, pready, pslverr;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic err;
   logic [3:0] pstrb = '0;
   logic [7:0] mediaTicks, dmaTicks, t;
   logic [7:0] vals [4] = '{8'h01, 8'h6b, 8'h94, 8'h3e};
   pmc_ctrl_t ctrl;
   int failures = 0, nTests = 0;
   // Clock
   always #50 clk = ~clk;
   pmc_regs dut_u (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .ctrl);
   pmc_macro_model model_u (.clk, .sys_rst, .ctrl, .mediaTicks, .dmaTicks);
   // One transfer; request held until pready is seen at an edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
      input logic [3:0] s);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      r = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
      xfer(1'h0, a, 8'h00, 4'h0);
      `CHK({err, r}, {1'h0, 24'h0, e})
   endtask
   task print_verdict();
      if (failures == 0 && nTests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Hang guard, far beyond the ninety or so cycles needed
   initial begin
      repeat (3000) @(posedge clk);
      failures++;
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'h0;
      chk_rd(PMC_OSC_OFFSET, 8'h8c);
      chk_rd(PMC_MACRO_OFFSET, 8'h00);
      `CHK(ctrl, 11'h007)
      // Fixed oscillator bits ignore a write of 10h that sets only bit 4
      xfer(1'h1, PMC_OSC_OFFSET, 8'h10, 4'h1);
      chk_rd(PMC_OSC_OFFSET, 8'h9c);
      `CHK(ctrl[10:9], 2'h3)
      // Every legal pll code, each control bit both ways
      foreach (vals[i]) begin
         xfer(1'h1, PMC_MACRO_OFFSET, vals[i], 4'h1);
         chk_rd(PMC_MACRO_OFFSET, vals[i]);
         `CHK(ctrl[8:0], {vals[i][7:6], 1'h0, vals[i][5:3], ~vals[i][2:0]})
      end
      // Media clock stopped: far side sees no edges
      t = mediaTicks;
      repeat (4) @(posedge clk);
      `CHK(mediaTicks, t)
      // Macro held in reset clears the dma side activity
      `CHK(dmaTicks, 8'h00)
      // Lane off leaves the bank alone; unmapped address reads zero
      xfer(1'h1, PMC_MACRO_OFFSET, 8'h00, 4'h0);
      chk_rd(PMC_MACRO_OFFSET, 8'h3e);
      xfer(1'h1, 12'h008, 8'hff, 4'h1);
      chk_rd(12'h008, 8'h00);
      // Mid-run reset
      @(posedge clk);
      sys_rst <= 1'h1;
      repeat (6) @(posedge clk);
      sys_rst <= 1'h0;
      chk_rd(PMC_OSC_OFFSET, 8'h8c);
      chk_rd(PMC_MACRO_OFFSET, 8'h00);
      `CHK(ctrl, 11'h007)
      print_verdict();
   end
endmodule
bind pmc_regs pmc_regs_asserts chk_u (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .pready, .ctrl);
